/* File: dcc_pkg.sv */
package dcc_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [3:0] ADDR_CTRL0 = 4'h0;
	localparam logic [3:0] ADDR_CTRL1 = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam logic [3:0] ADDR_CLEAR = 4'h3;
	localparam logic [3:0] ADDR_IRQ_EN = 4'h4;
	localparam logic [3:0] ADDR_ROUTE = 4'h5;
	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int NEG_HYST_LSB = 0;
	localparam int POS_HYST_LSB = 2;
	localparam int RESET_SRC_BIT = 4;
	localparam int OUTPUT_STATE_BIT = 6;
	localparam int ENABLE_BIT = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// ----------------------------------------
	// Status layout: bit 2*n falling, bit 2*n+1 rising for comparator n.
	// ----------------------------------------
	localparam int FALL_FLAG_LSB = 0;
	localparam int RISE_FLAG_LSB = 1;
	localparam logic [3:0] FLAGS_RESET = 4'h0;
	// ----------------------------------------
	// Route register: bit n routes comparator n, bit n+2 selects push-pull.
	// ----------------------------------------
	localparam int PUSH_PULL_LSB = 2;
	localparam logic [3:0] ROUTE_RESET = 4'h0;
	// ----------------------------------------
	// Hysteresis codes
	// ----------------------------------------
	localparam logic [1:0] HYST_OFF = 2'h0;
	localparam logic [1:0] HYST_2MV = 2'h1;
	localparam logic [1:0] HYST_4MV = 2'h2;
	localparam logic [1:0] HYST_10MV = 2'h3;
	// ----------------------------------------
	// Settling time
	// ----------------------------------------
	localparam int SETTLE_US = 20;
	localparam int CLK_MHZ = 100;
	localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
endpackage : dcc_pkg

/* File: dcc_channel.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// One comparator: synchroniser, edge detect, settle counter (flag only, outputs not blanked).
// ----------------------------------------
module dcc_channel #(
	parameter int SETTLE = dcc_pkg::SETTLE_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic raw_in,
	output logic level,
	output logic settled,
	output logic rise_pulse,
	output logic fall_pulse
);
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic [11:0] cnt;
		logic settled;
	} dcc_ch_state_t;

	dcc_ch_state_t state_reg;
	dcc_ch_state_t state_next;

	always_comb begin
		state_next = state_reg;
		state_next.sync1 = raw_in;
		state_next.sync2 = state_reg.sync1;
		state_next.prev = state_reg.sync2;
		if (!enable) begin
			state_next.cnt = 12'h000;
			state_next.settled = 1'b0;
		end else if (!state_reg.settled) begin
			if (state_reg.cnt == 12'(SETTLE - 1)) begin
				state_next.settled = 1'b1;
			end else begin
				state_next.cnt = state_reg.cnt + 12'h001;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Output forced low while shut down, edges only when enabled.
	assign level = enable & state_reg.sync2;
	assign settled = state_reg.settled;
	assign rise_pulse = enable & state_reg.sync2 & ~state_reg.prev;
	assign fall_pulse = enable & ~state_reg.sync2 & state_reg.prev;
endmodule : dcc_channel
`default_nettype wire

/* File: dcc_top.sv */
`timescale 1ns/10ps
`default_nettype none
module dcc_top #(
	parameter int SETTLE = dcc_pkg::SETTLE_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic [1:0] comp_raw,
	output logic [1:0] comp_enable,
	output logic [1:0] neg_hysteresis_select_0,
	output logic [1:0] positive_hysteresis_select_0,
	output logic [1:0] neg_hysteresis_select_1,
	output logic [1:0] positive_hysteresis_select_1,
	output logic reset_request,
	output logic [1:0] pin_out,
	output logic [1:0] pin_oe,
	output logic [1:0] output_settled,
	output logic irq
);
	typedef struct packed {
		logic [7:0] ctrl0;
		logic [7:0] ctrl1;
		logic [3:0] flags;
		logic [3:0] irq_en;
		logic [3:0] route;
		logic [7:0] rdata;
		logic reset_req;
		logic [1:0] pin_out;
		logic [1:0] pin_oe;
		logic [1:0] settled;
		logic irq;
	} dcc_state_t;

	dcc_state_t state_reg;
	dcc_state_t state_next;
	logic [1:0] level;
	logic [1:0] settled;
	logic [1:0] rise;
	logic [1:0] fall;
	logic [1:0] en;

	// ----------------------------------------
	// Per-comparator front end
	// ----------------------------------------
	assign en[0] = state_reg.ctrl0[dcc_pkg::ENABLE_BIT];
	assign en[1] = state_reg.ctrl1[dcc_pkg::ENABLE_BIT];

	// Each channel retimes its raw level through two flip-flops before edge detection.
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			dcc_channel #(
				.SETTLE(SETTLE)
			) u_ch (
				.clk(clk),
				.rst(rst),
				.enable(en[g]),
				.raw_in(comp_raw[g]),
				.level(level[g]),
				.settled(settled[g]),
				.rise_pulse(rise[g]),
				.fall_pulse(fall[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Registers, flags and pin control
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		if (wr) begin
			case (addr)
				dcc_pkg::ADDR_CTRL0: begin
					state_next.ctrl0 = wdata;
				end
				dcc_pkg::ADDR_CTRL1: begin
					state_next.ctrl1 = wdata;
					state_next.ctrl1[dcc_pkg::RESET_SRC_BIT] = 1'b0;
				end
				dcc_pkg::ADDR_CLEAR: begin
					state_next.flags = state_reg.flags & ~wdata[3:0];
				end
				dcc_pkg::ADDR_IRQ_EN: begin
					state_next.irq_en = wdata[3:0];
				end
				dcc_pkg::ADDR_ROUTE: begin
					state_next.route = wdata[3:0];
				end
				default: begin
				end
			endcase
		end
		// Sets come after the clear so a same-cycle event is kept.
		for (int i = 0; i < 2; i++) begin
			if (fall[i]) begin
				state_next.flags[2 * i + dcc_pkg::FALL_FLAG_LSB] = 1'b1;
			end
			if (rise[i]) begin
				state_next.flags[2 * i + dcc_pkg::RISE_FLAG_LSB] = 1'b1;
			end
			// Pin low when shut down; open drain drives only the low level.
			state_next.pin_out[i] = level[i];
			if (!state_reg.route[i]) begin
				state_next.pin_oe[i] = 1'b0;
			end else if (state_reg.route[dcc_pkg::PUSH_PULL_LSB + i]) begin
				state_next.pin_oe[i] = 1'b1;
			end else begin
				state_next.pin_oe[i] = ~level[i];
			end
		end
		state_next.settled = settled;
		state_next.reset_req = state_reg.ctrl0[dcc_pkg::RESET_SRC_BIT] & level[0];
		state_next.irq = |(state_next.flags & state_next.irq_en);
		state_next.rdata = 8'h00;
		if (rd) begin
			case (addr)
				dcc_pkg::ADDR_CTRL0: begin
					state_next.rdata = state_reg.ctrl0;
					state_next.rdata[dcc_pkg::OUTPUT_STATE_BIT] = level[0];
				end
				dcc_pkg::ADDR_CTRL1: begin
					state_next.rdata = state_reg.ctrl1;
					state_next.rdata[dcc_pkg::OUTPUT_STATE_BIT] = level[1];
				end
				dcc_pkg::ADDR_STATUS: begin
					state_next.rdata = {4'h0, state_reg.flags};
				end
				dcc_pkg::ADDR_IRQ_EN: begin
					state_next.rdata = {4'h0, state_reg.irq_en};
				end
				dcc_pkg::ADDR_ROUTE: begin
					state_next.rdata = {4'h0, state_reg.route};
				end
				default: begin
					state_next.rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg.ctrl0 <= dcc_pkg::CTRL_RESET;
			state_reg.ctrl1 <= dcc_pkg::CTRL_RESET;
			state_reg.flags <= dcc_pkg::FLAGS_RESET;
			state_reg.irq_en <= 4'h0;
			state_reg.route <= dcc_pkg::ROUTE_RESET;
			state_reg.rdata <= 8'h00;
			state_reg.reset_req <= 1'b0;
			state_reg.pin_out <= 2'h0;
			state_reg.pin_oe <= 2'h0;
			state_reg.settled <= 2'h0;
			state_reg.irq <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rdata = state_reg.rdata;
	assign comp_enable = {
		state_reg.ctrl1[dcc_pkg::ENABLE_BIT],
		state_reg.ctrl0[dcc_pkg::ENABLE_BIT]
	};
	assign neg_hysteresis_select_0 = state_reg.ctrl0[dcc_pkg::NEG_HYST_LSB +: 2];
	assign positive_hysteresis_select_0 = state_reg.ctrl0[dcc_pkg::POS_HYST_LSB +: 2];
	assign neg_hysteresis_select_1 = state_reg.ctrl1[dcc_pkg::NEG_HYST_LSB +: 2];
	assign positive_hysteresis_select_1 = state_reg.ctrl1[dcc_pkg::POS_HYST_LSB +: 2];
	assign reset_request = state_reg.reset_req;
	assign pin_out = state_reg.pin_out;
	assign pin_oe = state_reg.pin_oe;
	assign output_settled = state_reg.settled;
	assign irq = state_reg.irq;
endmodule : dcc_top
`default_nettype wire

/* File: dcc_properties.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Port checks
// ----------------------------------------
module dcc_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic [1:0] comp_raw,
	input wire logic [1:0] comp_enable,
	input wire logic [1:0] neg_hysteresis_select_0,
	input wire logic [1:0] positive_hysteresis_select_1,
	input wire logic [1:0] pin_out,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_enable_follow: assert property (
		wr && addr == 4'h0 |=> comp_enable[0] == $past(wdata[7])) else $error("enable bit");
	a_neg_hyst: assert property (
		wr && addr == 4'h0 |=> neg_hysteresis_select_0 == $past(wdata[1:0])) else $error("neg code");
	a_pos_hyst_one: assert property (
		wr && addr == 4'h1 |=> positive_hysteresis_select_1 == $past(wdata[3:2]))
		else $error("pos code");
	a_pin_low_off: assert property (!comp_enable[0] [*2] |-> !pin_out[0])
		else $error("pin 0 not low");
	a_pin_one_off: assert property (!comp_enable[1] [*2] |-> !pin_out[1])
		else $error("pin 1 not low");
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("rdata not idle");
	a_irq_sticky: assert property (
		irq && !(wr && (addr == 4'h3 || addr == 4'h4)) |=> irq) else $error("irq dropped");
	a_sync_delay: assert property (
		$stable(comp_raw[0]) [*3] ##1 $rose(comp_raw[0]) |=> !$rose(pin_out[0]) [*2])
		else $error("pin too fast");
endmodule : dcc_checker
bind dcc_top dcc_checker u_dcc_checker (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .comp_raw(comp_raw), .comp_enable(comp_enable),
	.neg_hysteresis_select_0(neg_hysteresis_select_0),
	.positive_hysteresis_select_1(positive_hysteresis_select_1), .pin_out(pin_out), .irq(irq));
`default_nettype wire

/* File: dcc_analog_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Analog core
// ----------------------------------------
module dcc_analog_model #(
	parameter int DLY = 3
) (
	input wire logic clk,
	input wire logic [1:0] enable,
	input wire logic [1:0] level,
	output logic [1:0] raw
);
	initial raw = 2'h0;
	// A core in shutdown gives no valid level, so its output chatters every cycle.
	always @(posedge clk) begin
		raw <= #DLY (enable & level) | (~enable & ~raw);
	end
endmodule : dcc_analog_model
`default_nettype wire

/* File: dcc_top_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module dcc_top_bench;
	logic clk, rst, wr, rd, irq, reset_request;
	logic [3:0] addr;
	logic [7:0] wdata, rdata;
	logic [1:0] comp_raw, comp_enable, lvl, pin_out, pin_oe, output_settled, nh0, ph0, nh1, ph1;
	int error_cnt = 0;
	int num_checks = 0;
	// Short settle count keeps the run brief; the counter logic is unchanged.
	localparam int SIM_SETTLE = 8;
	dcc_top #(.SETTLE(SIM_SETTLE)) u_dcc_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .comp_raw(comp_raw), .comp_enable(comp_enable),
		.neg_hysteresis_select_0(nh0), .positive_hysteresis_select_0(ph0),
		.neg_hysteresis_select_1(nh1), .positive_hysteresis_select_1(ph1),
		.reset_request(reset_request), .pin_out(pin_out), .pin_oe(pin_oe),
		.output_settled(output_settled), .irq(irq));
	dcc_analog_model u_dcc_analog_model (.clk(clk), .enable(comp_enable), .level(lvl),
		.raw(comp_raw));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wr_reg
	task rd_chk(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk("rdata", rdata, e);
	endtask : rd_chk
	task set_lvl(input logic [1:0] v);
		@(posedge clk);
		lvl <= v;
		repeat (6) @(posedge clk);
		#1;
	endtask : set_lvl
	task finish_test;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test
	initial begin
		#20000;
		error_cnt++;
		finish_test();
	end
	initial begin
		logic [1:0] c;
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		lvl = 2'h0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd_chk(4'h0, 8'h00);
		rd_chk(4'h2, 8'h00);
		rd_chk(4'hf, 8'h00);
		for (int i = 0; i < 4; i++) begin
			c = i[1:0];
			wr_reg(4'h0, {4'h9, c, ~c});
			wr_reg(4'h1, {4'h9, c, ~c});
			chk("hyst0", {4'h0, ph0, nh0}, {4'h0, c, ~c});
			chk("hyst1", {4'h0, ph1, nh1}, {4'h0, c, ~c});
		end
		repeat (20) if (output_settled !== 2'h3) @(posedge clk);
		#1;
		chk("settled", 8'(output_settled), 8'h03);
		wr_reg(4'h3, 8'h0f);
		wr_reg(4'h4, 8'h0f);
		wr_reg(4'h5, 8'h07);
		rd_chk(4'h2, 8'h00);
		rd_chk(4'h1, 8'h8c);
		$display("test setup done");
		set_lvl(2'h3);
		rd_chk(4'h2, 8'h0a);
		rd_chk(4'h0, 8'hdc);
		chk("irq", 8'(irq), 8'h01);
		chk("rstreq", 8'(reset_request), 8'h01);
		chk("pin", {2'h0, pin_oe, 2'h0, pin_out}, 8'h13);
		set_lvl(2'h0);
		rd_chk(4'h2, 8'h0f);
		chk("rstreq", 8'(reset_request), 8'h00);
		chk("pin", {2'h0, pin_oe, 2'h0, pin_out}, 8'h30);
		$display("test edges done");
		wr_reg(4'h3, 8'h05);
		rd_chk(4'h2, 8'h0a);
		chk("irq", 8'(irq), 8'h01);
		wr_reg(4'h4, 8'h05);
		chk("irq", 8'(irq), 8'h00);
		wr_reg(4'h3, 8'h0a);
		wr_reg(4'h4, 8'h0f);
		rd_chk(4'h2, 8'h00);
		$display("test clear done");
		wr_reg(4'h0, 8'h00);
		wr_reg(4'h1, 8'h00);
		set_lvl(2'h3);
		rd_chk(4'h2, 8'h00);
		chk("pin", {irq, 5'h0, pin_out}, 8'h00);
		chk("settled", 8'(output_settled), 8'h00);
		// Settled must appear exactly one settle count plus one cycle after the enable edge.
		wr_reg(4'h0, 8'h80);
		repeat (SIM_SETTLE) @(posedge clk);
		#1;
		chk("settled", 8'(output_settled), 8'h00);
		@(posedge clk);
		#1;
		chk("settled", 8'(output_settled), 8'h01);
		$display("test shutdown done");
		finish_test();
	end
endmodule : dcc_top_bench
`default_nettype wire
